/* src/alaw_port_pkg.sv */
// shared constants and carriers for the a-law codec serial pcm port
// Contract
// - frame pulse rise enables output; conversion starts on next conversion clock edge.
// - shift transmit word out on each bit clock rise while frame high.
// - frame pulse fall tri-states output; stays undriven while frame low.
// - transmit uses 8-bit shift register; bit clock 64 kHz to 2.1 MHz.
// - frame rising after bit clock rise counts as first shift edge.
// - receive conversion starts only after rx frame falls.
// - each received bit passes a master-slave stage, slave on clock rise.
// - rx frame rising after first bit clock rise is first receive edge.
// - word is sign, 3-bit chord, 4-bit step.
// - chord codes for segments one to eight: 101,100,111,110,001,000,011,010.
// - sixteen steps per chord; step doubles after second chord.
// - sign one positive, zero negative, same magnitude meaning.
// - received words use the transmit layout.
// - even-order bits of the a-law code are inverted.
// - offset null cycle precedes every conversion, not using sign bit.
// - conversions timed by conversion clock, asynchronous to port clocks.
// - first received bit loads when frame and bit clock both high.
package alaw_port_pkg;
    localparam int WORD_BITS = 8;
    localparam int CHORD_BITS = 3;
    localparam int STEP_BITS = 4;
    localparam int MAG_BITS = 12;
    localparam logic [7:0] EVEN_BIT_MASK = 8'h55;
    localparam int NULL_CYCLES = 1;
    localparam int CONV_CYCLES = 8;
    localparam int CONV_CNT_W = 4;

    typedef struct packed {
        logic sign;
        logic [CHORD_BITS-1:0] chord;
        logic [STEP_BITS-1:0] step;
    } code_word_s;

    typedef struct packed {
        logic negative;
        logic [MAG_BITS-1:0] magnitude;
    } sample_s;

    typedef enum logic [1:0] {CONV_IDLE, CONV_NULL, CONV_RUN} conv_state_e;
endpackage : alaw_port_pkg

/* src/alaw_shift_port.sv */
// serial shift stage sampling a bit clock and frame pulse
`timescale 1ns/1ps
module alaw_shift_port
    import alaw_port_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_bit_clock,
    input wire logic i_frame_pulse,
    input wire logic i_serial_in,
    input wire logic [WORD_BITS-1:0] i_load_word,
    output logic o_shift_edge,
    output logic o_frame_rise,
    output logic o_frame_fall,
    output logic o_serial_out,
    output logic [WORD_BITS-1:0] o_word
);
    logic clk_reg, clk_next;
    logic frame_reg, frame_next;
    logic master_reg, master_next;
    logic [WORD_BITS-1:0] sr_reg, sr_next;
    logic [WORD_BITS-1:0] base;
    logic clk_rise;

    always_comb begin
        clk_next = i_bit_clock;
        frame_next = i_frame_pulse;
        clk_rise = i_bit_clock & ~clk_reg;
        o_frame_rise = i_frame_pulse & ~frame_reg;
        o_frame_fall = ~i_frame_pulse & frame_reg;
        // late frame rise with the clock already high stands in for the first edge
        o_shift_edge = i_frame_pulse & ((clk_rise & ~o_frame_rise) | (o_frame_rise & i_bit_clock));
        master_next = i_serial_in;
        // a frame rise loads first, so a coinciding first edge shifts the new word, not a stale one
        base = o_frame_rise ? i_load_word : sr_reg;
        sr_next = base;
        if (o_shift_edge) begin
            // master captured last cycle moves to slave on the edge
            sr_next = {base[WORD_BITS-2:0], master_reg};
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            clk_reg <= 1'b0;
            frame_reg <= 1'b0;
            master_reg <= 1'b0;
            sr_reg <= '0;
        end else begin
            clk_reg <= clk_next;
            frame_reg <= frame_next;
            master_reg <= master_next;
            sr_reg <= sr_next;
        end
    end

    assign o_serial_out = base[WORD_BITS-1];
    assign o_word = sr_reg;
endmodule : alaw_shift_port

/* src/alaw_codec_serial_pcm_port.sv */
// top: a-law codec digital side with serial pcm transmit and receive ports
`timescale 1ns/1ps
module alaw_codec_serial_pcm_port
    import alaw_port_pkg::*;
#(
    parameter int CONV_DIV = 16
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_tx_bit_clock,
    input wire logic i_tx_frame_pulse,
    input wire logic i_rx_bit_clock,
    input wire logic i_rx_frame_pulse,
    input wire logic i_serial_code_in,
    input wire logic [MAG_BITS:0] i_adc_sample,
    output logic o_serial_code_out,
    output logic o_serial_code_out_oe,
    output logic o_adc_null,
    output logic o_adc_sample_strobe,
    output logic [MAG_BITS:0] o_dac_sample,
    output logic o_dac_strobe
);
    // the divider counter is 16 bits wide
    if (CONV_DIV < 2 || CONV_DIV > 65536) begin : g_bad_div
        $error("CONV_DIV must lie between 2 and 65536");
    end

    ////////////////////////////////////////////////////////////////////////////
    // encode and decode helpers

    // segment index 0..7 to on-line chord code, inversion included
    function automatic logic [CHORD_BITS-1:0] seg_to_chord(input logic [2:0] seg);
        seg_to_chord = seg ^ 3'h5;
    endfunction : seg_to_chord

    function automatic code_word_s encode(input sample_s s);
        logic [2:0] seg;
        logic [STEP_BITS-1:0] st;
        code_word_s w;
        seg = 3'h0;
        st = s.magnitude[4:1];
        for (int k = 7; k >= 1; k--) begin
            if (seg == 3'h0 && s.magnitude[k+4]) begin
                seg = 3'(k);
                st = s.magnitude[k+3 -: 4];
            end
        end
        w.sign = ~s.negative;
        w.chord = seg_to_chord(seg);
        w.step = st ^ EVEN_BIT_MASK[3:0];
        encode = w;
    endfunction : encode

    function automatic sample_s decode(input code_word_s w);
        logic [2:0] seg;
        logic [STEP_BITS-1:0] st;
        logic [MAG_BITS-1:0] m;
        sample_s s;
        seg = seg_to_chord(w.chord);
        st = w.step ^ EVEN_BIT_MASK[3:0];
        m = {7'h00, st, 1'b1}; // mid-step reconstruction
        if (seg != 3'h0) begin
            m = {6'h00, 1'b1, st, 1'b1} << (seg - 3'h1);
        end
        s.negative = ~w.sign;
        s.magnitude = m;
        decode = s;
    endfunction : decode

    ////////////////////////////////////////////////////////////////////////////
    // conversion clock divider, free of the port clocks

    logic [15:0] div_reg, div_next;
    logic conv_tick;

    always_comb begin
        conv_tick = (div_reg == 16'(CONV_DIV - 1));
        div_next = conv_tick ? 16'h0000 : div_reg + 16'h0001;
    end

    ////////////////////////////////////////////////////////////////////////////
    // transmit port

    logic tx_edge, tx_rise, tx_fall, tx_out;
    code_word_s tx_word_reg, tx_word_next;

    alaw_shift_port u_tx (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_bit_clock(i_tx_bit_clock),
        .i_frame_pulse(i_tx_frame_pulse),
        .i_serial_in(1'b0),
        .i_load_word(tx_word_reg),
        .o_shift_edge(tx_edge),
        .o_frame_rise(tx_rise),
        .o_frame_fall(tx_fall),
        .o_serial_out(tx_out),
        .o_word()
    );

    logic oe_reg, oe_next;
    logic data_reg, data_next;

    always_comb begin
        oe_next = oe_reg;
        data_next = data_reg;
        if (tx_rise) oe_next = 1'b1;
        if (tx_fall || !i_tx_frame_pulse) oe_next = 1'b0;
        if (tx_edge) data_next = tx_out;
    end

    ////////////////////////////////////////////////////////////////////////////
    // conversion sequencer: offset null, then sample

    conv_state_e conv_reg, conv_next;
    logic conv_pend_reg, conv_pend_next;
    logic [CONV_CNT_W-1:0] cnt_reg, cnt_next;
    logic null_reg, null_next;
    logic samp_reg, samp_next;

    always_comb begin
        conv_next = conv_reg;
        cnt_next = cnt_reg;
        conv_pend_next = conv_pend_reg | tx_rise;
        tx_word_next = tx_word_reg;
        null_next = 1'b0;
        samp_next = 1'b0;
        unique case (conv_reg)
            CONV_IDLE: begin
                if (conv_pend_reg && conv_tick) begin
                    conv_next = CONV_NULL;
                    conv_pend_next = tx_rise;
                    cnt_next = CONV_CNT_W'(NULL_CYCLES);
                end
            end
            CONV_NULL: begin
                null_next = 1'b1;
                if (conv_tick) begin
                    cnt_next = cnt_reg - 1'b1;
                    if (cnt_reg == CONV_CNT_W'(1)) begin
                        conv_next = CONV_RUN;
                        cnt_next = CONV_CNT_W'(CONV_CYCLES);
                    end
                end
            end
            CONV_RUN: begin
                if (conv_tick) begin
                    cnt_next = cnt_reg - 1'b1;
                    if (cnt_reg == CONV_CNT_W'(1)) begin
                        samp_next = 1'b1;
                        tx_word_next = encode(i_adc_sample);
                        conv_next = CONV_IDLE;
                    end
                end
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // receive port and d/a hand-off

    logic rx_fall;
    logic [WORD_BITS-1:0] rx_word;
    logic [MAG_BITS:0] dac_reg, dac_next;
    logic dstb_reg, dstb_next;

    alaw_shift_port u_rx (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_bit_clock(i_rx_bit_clock),
        .i_frame_pulse(i_rx_frame_pulse),
        .i_serial_in(i_serial_code_in),
        .i_load_word('0),
        .o_shift_edge(),
        .o_frame_rise(),
        .o_frame_fall(rx_fall),
        .o_serial_out(),
        .o_word(rx_word)
    );

    always_comb begin
        dac_next = dac_reg;
        dstb_next = 1'b0;
        if (rx_fall) begin
            dac_next = decode(rx_word);
            dstb_next = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state registers

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            div_reg <= '0;
            oe_reg <= 1'b0;
            data_reg <= 1'b0;
            conv_reg <= CONV_IDLE;
            conv_pend_reg <= 1'b0;
            cnt_reg <= '0;
            null_reg <= 1'b0;
            samp_reg <= 1'b0;
            tx_word_reg <= '0;
            dac_reg <= '0;
            dstb_reg <= 1'b0;
        end else begin
            div_reg <= div_next;
            oe_reg <= oe_next;
            data_reg <= data_next;
            conv_reg <= conv_next;
            conv_pend_reg <= conv_pend_next;
            cnt_reg <= cnt_next;
            null_reg <= null_next;
            samp_reg <= samp_next;
            tx_word_reg <= tx_word_next;
            dac_reg <= dac_next;
            dstb_reg <= dstb_next;
        end
    end

    assign o_serial_code_out = data_reg;
    assign o_serial_code_out_oe = oe_reg;
    assign o_adc_null = null_reg;
    assign o_adc_sample_strobe = samp_reg;
    assign o_dac_sample = dac_reg;
    assign o_dac_strobe = dstb_reg;
endmodule : alaw_codec_serial_pcm_port

/* sim/alaw_port_monitor.sv */
// assertion checker for the a-law serial pcm port top
`timescale 1ns/1ps
module alaw_port_monitor
    import alaw_port_pkg::*;
#(
    parameter int CONV_DIV = 16
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_tx_bit_clock,
    input wire logic i_tx_frame_pulse,
    input wire logic i_rx_frame_pulse,
    input wire logic o_serial_code_out,
    input wire logic o_serial_code_out_oe,
    input wire logic o_adc_null,
    input wire logic o_adc_sample_strobe,
    input wire logic [MAG_BITS:0] o_dac_sample,
    input wire logic o_dac_strobe
);
    // null span carries one cycle of slack and conversion span one tick plus a cycle; tick span has none
    localparam int TICK_SPAN = CONV_DIV + 2;
    localparam int NULL_SPAN = NULL_CYCLES * CONV_DIV + 1;
    localparam int CONV_SPAN = (CONV_CYCLES + 1) * CONV_DIV;
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    ////////////////////////////////////////////////////////////////
    chk_oe_on_rise: assert property ($rose(i_tx_frame_pulse) |=> o_serial_code_out_oe)
        else $error("output not enabled after frame rise");
    chk_oe_off_low: assert property (!i_tx_frame_pulse |=> !o_serial_code_out_oe)
        else $error("output driven while frame low");
    chk_out_holds: assert property (i_tx_frame_pulse && $past(i_tx_frame_pulse) && !$rose(i_tx_bit_clock)
        |=> $stable(o_serial_code_out))
        else $error("serial out moved without a shift edge");
    chk_conv_start: assert property ($rose(i_tx_frame_pulse) |-> ##[1:TICK_SPAN] o_adc_null)
        else $error("no null phase after frame rise");
    chk_null_ends: assert property ($rose(o_adc_null) |-> ##[1:NULL_SPAN] !o_adc_null)
        else $error("null phase too long");
    chk_conv_done: assert property ($fell(o_adc_null) |-> ##[1:CONV_SPAN] o_adc_sample_strobe)
        else $error("conversion did not finish");
    chk_dac_on_fall: assert property ($fell(i_rx_frame_pulse) |=> o_dac_strobe)
        else $error("no dac update after rx frame fall");
    chk_dac_cause: assert property (o_dac_strobe |-> $past(i_rx_frame_pulse, 2) && !$past(i_rx_frame_pulse))
        else $error("dac update without rx frame fall");
    chk_dac_holds: assert property (!o_dac_strobe |-> $stable(o_dac_sample))
        else $error("dac sample moved without strobe");
    cover property ($rose(i_tx_frame_pulse) && i_tx_bit_clock);
    cover property (o_adc_sample_strobe);
    cover property (o_dac_strobe);
endmodule : alaw_port_monitor

bind alaw_codec_serial_pcm_port alaw_port_monitor #(.CONV_DIV(CONV_DIV)) u_alaw_port_monitor (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_tx_bit_clock(i_tx_bit_clock),
    .i_tx_frame_pulse(i_tx_frame_pulse), .i_rx_frame_pulse(i_rx_frame_pulse),
    .o_serial_code_out(o_serial_code_out), .o_serial_code_out_oe(o_serial_code_out_oe),
    .o_adc_null(o_adc_null), .o_adc_sample_strobe(o_adc_sample_strobe),
    .o_dac_sample(o_dac_sample), .o_dac_strobe(o_dac_strobe));

/* sim/pcm_mux_model.sv */
// pcm multiplex system model: frames, bit clocks and receive data
`timescale 1ns/1ps
module pcm_mux_model (
    input wire logic i_ref_clk,
    input wire logic i_serial_code_out,
    output logic o_tx_bit_clock,
    output logic o_tx_frame_pulse,
    output logic o_rx_bit_clock,
    output logic o_rx_frame_pulse,
    output logic o_serial_code_in
);
    // bit clocks stand still low outside frames, except that a late frame raises its bit clock one cycle before the frame rises
    initial begin
        o_tx_bit_clock = 1'b0;
        o_tx_frame_pulse = 1'b0;
        o_rx_bit_clock = 1'b0;
        o_rx_frame_pulse = 1'b0;
        o_serial_code_in = 1'b1;
    end
    task automatic cyc(input int n);
        repeat (n) @(negedge i_ref_clk);
    endtask : cyc
    // late: bit clock already high when the frame rises, so the frame edge shifts
    task automatic send(input int h, input bit late, output logic [7:0] w);
        if (late) begin
            o_tx_bit_clock = 1'b1;
            cyc(1);
        end
        o_tx_frame_pulse = 1'b1;
        for (int i = 7; i >= 0; i--) begin
            if (!(late && i == 7)) begin
                cyc(h);
                o_tx_bit_clock = 1'b1;
            end
            cyc(h);
            w[i] = i_serial_code_out;
            o_tx_bit_clock = 1'b0;
        end
        o_tx_frame_pulse = 1'b0;
    endtask : send
    task automatic recv(input int h, input bit late, input logic [7:0] w);
        o_serial_code_in = w[7];
        if (late) begin
            cyc(1);
            o_rx_bit_clock = 1'b1;
            cyc(1);
        end
        o_rx_frame_pulse = 1'b1;
        for (int i = 7; i >= 0; i--) begin
            if (i < 7) o_serial_code_in = w[i];
            if (!(late && i == 7)) begin
                cyc(h);
                o_rx_bit_clock = 1'b1;
            end
            cyc(h);
            o_rx_bit_clock = 1'b0;
        end
        o_rx_frame_pulse = 1'b0;
        // released data line shows the inverse, not a stale bit
        o_serial_code_in = ~w[0];
    endtask : recv
endmodule : pcm_mux_model

/* sim/alaw_codec_serial_pcm_port_tb_top.sv */
// self-checking bench for the a-law serial pcm port
`timescale 1ns/1ps
module alaw_codec_serial_pcm_port_tb_top;
    import alaw_port_pkg::*;
    localparam int DIV = 4;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [MAG_BITS:0] adc = '0;
    logic tx_clk, tx_fr, rx_clk, rx_fr, sin, sout, oe, nul, astb, dstb;
    logic [MAG_BITS:0] dac;
    logic [MAG_BITS:0] dac_seen = '0;
    int errors = 0;
    int n_compared = 0;
    int seed = 32'he729;
    int n_adc = 0;
    int n_dac = 0;
    always #20 clk = ~clk;
    alaw_codec_serial_pcm_port #(.CONV_DIV(DIV)) u_alaw_codec_serial_pcm_port (
        .i_ref_clk(clk), .i_rst_n(rst_n), .i_tx_bit_clock(tx_clk), .i_tx_frame_pulse(tx_fr),
        .i_rx_bit_clock(rx_clk), .i_rx_frame_pulse(rx_fr), .i_serial_code_in(sin), .i_adc_sample(adc),
        .o_serial_code_out(sout), .o_serial_code_out_oe(oe), .o_adc_null(nul),
        .o_adc_sample_strobe(astb), .o_dac_sample(dac), .o_dac_strobe(dstb));
    pcm_mux_model u_pcm_mux_model (
        .i_ref_clk(clk), .i_serial_code_out(sout), .o_tx_bit_clock(tx_clk), .o_tx_frame_pulse(tx_fr),
        .o_rx_bit_clock(rx_clk), .o_rx_frame_pulse(rx_fr), .o_serial_code_in(sin));
    always @(posedge clk) begin
        if (astb === 1'b1) n_adc <= n_adc + 1;
        if (dstb === 1'b1) n_dac <= n_dac + 1;
        if (dstb === 1'b1) dac_seen <= dac;
    end
    ////////////////////////////////////////////////////////////////
    function automatic logic [7:0] enc(input logic [12:0] s);
        logic [2:0] seg;
        logic [11:0] sh;
        seg = 3'h0;
        for (int i = 1; i < 8; i++) if (s[4 + i]) seg = 3'(i);
        sh = s[11:0] >> ((seg == 3'h0) ? 3'h1 : seg);
        return {~s[12], seg ^ 3'h5, sh[3:0] ^ 4'h5};
    endfunction : enc
    // decode lands mid-step; chord zero has no implied leading one
    function automatic logic [12:0] dec(input logic [7:0] w);
        logic [2:0] seg;
        logic [11:0] m;
        seg = w[6:4] ^ 3'h5;
        m = {6'h00, 1'b1, w[3:0] ^ 4'h5, 1'b1};
        if (seg == 3'h0) m[5] = 1'b0;
        else m = m << (seg - 3'h1);
        return {~w[7], m};
    endfunction : dec
    task automatic check(input logic [12:0] got, input logic [12:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check
    task automatic final_report;
        if (errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : final_report
    initial begin
        repeat (30000) @(posedge clk);
        errors++;
        $display("FAIL %0t watchdog expired", $time);
        final_report();
    end
    initial begin
        logic [7:0] got;
        logic [7:0] rxw;
        logic [7:0] exp;
        int h;
        exp = 8'h00;
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        for (int it = 0; it < 16; it++) begin
            // half periods of 6 to 11 ref cycles keep both bit clocks at or below 2.1 MHz
            h = 6 + ($unsigned($random(seed)) % 5);
            if (it == 15) h = 194;
            rxw = 8'($random(seed));
            adc = 13'($random(seed));
            // first eight frames walk every chord in both directions
            if (it < 8) adc = {it[0], 12'h010 << it};
            if (it < 8) rxw[6:4] = it[2:0];
            fork
                u_pcm_mux_model.send(h, it[1], got);
                u_pcm_mux_model.recv(h + it[0], it[1] ^ it[2], rxw);
            join
            check({5'h00, got}, {5'h00, exp}, "tx word");
            exp = enc(adc);
            repeat (17 * DIV + 4) @(negedge clk);
            check(dac_seen, dec(rxw), "rx word");
            check(13'(n_adc), 13'(it + 1), "conversions");
            check(13'(n_dac), 13'(it + 1), "dac updates");
            check({12'h000, oe}, 13'h0000, "oe idle");
        end
        // one more frame carries the word of the last conversion
        u_pcm_mux_model.send(6, 1'b1, got);
        check({5'h00, got}, {5'h00, exp}, "last tx word");
        final_report();
    end
endmodule : alaw_codec_serial_pcm_port_tb_top
